// ### hbr_pkg.sv
package hbr_pkg;

   // ----------------------------------------------------------------
   // Timing and widths
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int RETRY_WIDTH = 4;
   localparam int ADDR_WIDTH = 32;
   localparam int SYNC_STAGES = 2;
   localparam logic [RETRY_WIDTH-1:0] RETRY_ZERO = 4'h0;
   localparam logic [ADDR_WIDTH-1:0] ADDR_RESET = 32'h0000_0000;
   localparam logic [ADDR_WIDTH-1:0] ADDR_STEP = 32'h0000_0002;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      HBR_IDLE,
      HBR_REQ,
      HBR_OWN,
      HBR_XFER,
      HBR_RELEASE,
      HBR_HALT
   } hbr_state_e;

   // Raw inputs that arrive from the host side, unsynchronised.
   typedef struct packed {
      logic releaseReq;
      logic busOwned;
      logic busError;
      logic xferAck;
   } hbr_pins_s;

   // Status presented to the rest of the controller.
   typedef struct packed {
      logic owner;
      logic xferActive;
      logic errorSeen;
      logic halted;
   } hbr_status_s;

endpackage

// ### hbr_bus_release.sv
`timescale 1ns/10ps
module hbr_bus_release #(
   parameter int RW = hbr_pkg::RETRY_WIDTH,
   parameter int AW = hbr_pkg::ADDR_WIDTH
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic clkEn,
   input wire hbr_pkg::hbr_pins_s pins,
   input wire logic dmaStart,
   input wire logic [RW-1:0] error_retry_setting,
   input wire logic [AW-1:0] dmaStartAddr,
   input wire logic errorClear,
   output logic bus_request_out,
   output logic dmaCycleDone,
   output logic localDmaHalt,
   output logic [AW-1:0] host_dma_address_reg,
   output hbr_pkg::hbr_status_s status
);
   import hbr_pkg::*;

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   // Transfer acknowledge is also asynchronous, so it shares the chain.
   logic [3:0] syncA_reg;
   logic [3:0] syncB_reg;
   wire logic [3:0] rawPins = {pins.releaseReq, pins.busOwned, pins.busError, pins.xferAck};

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         syncA_reg <= 4'h0;
         syncB_reg <= 4'h0;
      end
      else if (clkEn)
      begin
         syncA_reg <= rawPins;
         syncB_reg <= syncA_reg;
      end
   end

   wire logic relReq = syncB_reg[3];
   wire logic owned = syncB_reg[2];
   wire logic busErr = syncB_reg[1];
   wire logic ack = syncB_reg[0];

   // ----------------------------------------------------------------
   // Control state machine
   // ----------------------------------------------------------------
   hbr_state_e state_reg;
   hbr_state_e state_next;
   logic releasePend_reg;
   logic errorPend_reg;
   logic firstXfer_reg;
   logic [RW-1:0] retryCnt_reg;
   logic busRq_reg;
   logic done_reg;
   logic localHalt_reg;
   logic errSeen_reg;
   logic [AW-1:0] addr_reg;

   wire logic inXfer = (state_reg == HBR_XFER);
   wire logic isOwner = owned && (state_reg == HBR_OWN || state_reg == HBR_XFER);
   // A release request is only seen while the bus is ours.
   wire logic relSeen = relReq && isOwner;
   // A bus error counts only during a DMA cycle on the host bus.
   wire logic errValid = busErr && inXfer;
   // An error ends the cycle even without acknowledge.
   wire logic xferEnd = inXfer && (ack || errValid);
   wire logic retryAllowed = (retryCnt_reg != RW'(RETRY_ZERO));
   wire logic doRetry = errValid && retryAllowed;
   wire logic errStop = errValid && !retryAllowed;
   wire logic startOk = dmaStart && !releasePend_reg && !relSeen;

   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         HBR_IDLE:
            if (dmaStart)
               state_next = HBR_REQ;
         HBR_REQ:
            if (owned)
               state_next = HBR_OWN;
         HBR_OWN:
            if (!owned)
               state_next = HBR_IDLE;
            else if (relSeen || releasePend_reg)
               state_next = HBR_RELEASE;
            else if (startOk)
               state_next = HBR_XFER;
         HBR_XFER:
            if (errStop)
               state_next = HBR_HALT;
            else if (doRetry)
               state_next = HBR_XFER;
            else if (xferEnd)
               state_next = (relSeen || releasePend_reg) ? HBR_RELEASE : HBR_OWN;
         HBR_RELEASE:
            if (!owned)
               state_next = HBR_IDLE;
         HBR_HALT:
            if (errorClear)
               state_next = HBR_IDLE;
         default:
            state_next = HBR_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         state_reg <= HBR_IDLE;
      else if (clkEn)
         state_reg <= state_next;
   end

   // ----------------------------------------------------------------
   // Pending flags and retry budget
   // ----------------------------------------------------------------
   // The release stays pending across the cycle that is already running.
   wire logic relPendNext = (state_next == HBR_IDLE) ? 1'b0 : (releasePend_reg || relSeen);
   wire logic [RW-1:0] retryNext = (state_reg == HBR_OWN && startOk) ? error_retry_setting :
                                   doRetry ? retryCnt_reg - 1'b1 : retryCnt_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         releasePend_reg <= 1'b0;
         errorPend_reg <= 1'b0;
         retryCnt_reg <= RW'(RETRY_ZERO);
      end
      else if (clkEn)
      begin
         releasePend_reg <= relPendNext;
         errorPend_reg <= errStop || (errorPend_reg && !errorClear);
         retryCnt_reg <= retryNext;
      end
   end

   // ----------------------------------------------------------------
   // Bus request
   // ----------------------------------------------------------------
   // Request stays up until the first owned transfer reaches its second state.
   wire logic firstXferT2 = inXfer && firstXfer_reg;
   wire logic busRqNext = (state_next == HBR_REQ) || (state_reg == HBR_REQ) ||
                          (busRq_reg && !firstXferT2 && state_reg != HBR_IDLE && state_next != HBR_IDLE);
   wire logic firstNext = (state_reg == HBR_REQ) ? 1'b1 : (inXfer ? 1'b0 : firstXfer_reg);

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         busRq_reg <= 1'b0;
         firstXfer_reg <= 1'b0;
      end
      else if (clkEn)
      begin
         busRq_reg <= busRqNext;
         firstXfer_reg <= firstNext;
      end
   end

   // ----------------------------------------------------------------
   // Outputs, local halt and address
   // ----------------------------------------------------------------
   // The address is left at the failing value after an error; callers
   // must not trust it, so no effort is spent restoring it.
   wire logic [AW-1:0] addrNext = (state_reg == HBR_OWN && startOk) ? dmaStartAddr :
                                  (xferEnd && !errValid) ? addr_reg + AW'(ADDR_STEP) : addr_reg;
   wire logic haltSet = errStop;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
      begin
         done_reg <= 1'b0;
         localHalt_reg <= 1'b0;
         errSeen_reg <= 1'b0;
         addr_reg <= AW'(ADDR_RESET);
      end
      else if (clkEn)
      begin
         done_reg <= xferEnd && !doRetry;
         localHalt_reg <= haltSet || (localHalt_reg && !errorClear);
         errSeen_reg <= errValid || (errSeen_reg && !errorClear);
         addr_reg <= addrNext;
      end
   end

   hbr_status_s status_reg;

   always_ff @(posedge clk_sys)
   begin
      if (!rst_n)
         status_reg <= '0;
      else if (clkEn)
         status_reg <= '{owner: (state_next == HBR_OWN || state_next == HBR_XFER),
                         xferActive: (state_next == HBR_XFER),
                         errorSeen: errValid || (errSeen_reg && !errorClear),
                         halted: (state_next == HBR_HALT)};
   end

   assign bus_request_out = busRq_reg;
   assign dmaCycleDone = done_reg;
   assign localDmaHalt = localHalt_reg;
   assign host_dma_address_reg = addr_reg;
   assign status = status_reg;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   a_release_ignored: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && state_reg == HBR_IDLE && relReq && !dmaStart) |=> state_reg == HBR_IDLE)
      else $error("Release request acted on while not owner.");
   a_release_after_xfer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && inXfer && relSeen && ack && !busErr) |=> state_reg == HBR_RELEASE)
      else $error("Bus not released after started cycle.");
   a_no_start_pending: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && state_reg == HBR_OWN && releasePend_reg) |=> state_reg != HBR_XFER)
      else $error("Transfer started with release pending.");
   a_error_ends_xfer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && errValid && !ack) |=> dmaCycleDone || state_reg == HBR_XFER)
      else $error("Errored transfer not completed.");
   a_retry_rerun: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && doRetry) |=> state_reg == HBR_XFER && !dmaCycleDone)
      else $error("Failed cycle not rerun.");
   a_zero_retry_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && errStop) |=> state_reg == HBR_HALT && !status.owner)
      else $error("Bus kept after unretried error.");
   a_error_outside: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && busErr && !inXfer && !errSeen_reg && !errorClear) |=> !status.errorSeen)
      else $error("Error outside DMA cycle was taken.");
   a_halt_holds: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && state_reg == HBR_HALT && !errorClear) |=> state_reg == HBR_HALT)
      else $error("DMA resumed after halting error.");
   a_halt_no_request: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == HBR_HALT) |-> !bus_request_out)
      else $error("Bus requested while halted.");
   a_halt_no_xfer: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == HBR_HALT) |-> !status.xferActive && !status.owner)
      else $error("Transfer shown while halted.");
   a_halt_local_level: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == HBR_HALT) |-> localDmaHalt)
      else $error("Local halt missing while halted.");
   a_local_clear: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && errorClear && !errStop) |=> !localDmaHalt)
      else $error("Local halt not cleared.");
   a_release_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (state_reg == HBR_RELEASE) |-> !status.xferActive)
      else $error("Transfer shown during release.");
   a_done_pulse: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && dmaCycleDone) |=> !dmaCycleDone)
      else $error("Done pulse longer than one cycle.");
   a_owner_status: assert property (@(posedge clk_sys) disable iff (!rst_n)
      status.owner == (state_reg == HBR_OWN || state_reg == HBR_XFER))
      else $error("Owner status disagrees with state.");
   a_error_taken: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && errValid) |=> status.errorSeen)
      else $error("Error during DMA cycle not recorded.");
   a_addr_step: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && xferEnd && !errValid) |=> host_dma_address_reg == $past(addr_reg) + AW'(ADDR_STEP))
      else $error("Address did not step after good transfer.");
   a_request_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && state_reg == HBR_IDLE && dmaStart) |=> bus_request_out)
      else $error("Bus request not raised.");
   a_local_halt: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && errStop) |=> localDmaHalt)
      else $error("Local side not halted.");
   a_request_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn && firstXferT2 && state_next != HBR_REQ) |=> !bus_request_out)
      else $error("Bus request not dropped at first transfer.");
   a_sync_delay: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (clkEn [*2]) |-> syncB_reg == $past(rawPins, 2))
      else $error("Synchroniser depth wrong.");

   c_normal: cover property (@(posedge clk_sys) disable iff (!rst_n) xferEnd && ack && !busErr);
   c_retry: cover property (@(posedge clk_sys) disable iff (!rst_n) doRetry);
   c_halt: cover property (@(posedge clk_sys) disable iff (!rst_n) errStop);
   c_release: cover property (@(posedge clk_sys) disable iff (!rst_n) state_reg == HBR_RELEASE);
   c_clear: cover property (@(posedge clk_sys) disable iff (!rst_n) state_reg == HBR_HALT && errorClear);

endmodule

// ### hbr_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Host arbiter and acknowledge model
// ----------------------------------------------------------------
module hbr_host_model (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic busReq,
   input wire logic xferActive,
   input wire logic letGo,
   input wire logic [7:0] ackDelay,
   output logic busOwned,
   output logic xferAck
);
   logic [7:0] waitCnt;

   // Changes land on the falling edge so the controller never samples a moving input.
   // A large ackDelay keeps the acknowledge away, as a slow or failing target would.
   always @(negedge clk_sys)
   begin
      if (!rst_n)
      begin
         busOwned <= 1'b0;
         xferAck <= 1'b0;
         waitCnt <= 8'h00;
      end
      else
      begin
         if (busReq && !letGo)
            busOwned <= 1'b1;
         else if (letGo && !xferActive)
            busOwned <= 1'b0;
         waitCnt <= xferActive ? waitCnt + 8'h01 : 8'h00;
         xferAck <= xferActive && (waitCnt >= ackDelay);
      end
   end
endmodule

// ### hbr_bus_release_tb.sv
`timescale 1ns/10ps
module hbr_bus_release_tb;
   import hbr_pkg::*;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic releaseReq = 1'b0;
   logic busError = 1'b0;
   logic dmaStart = 1'b0;
   logic errorClear = 1'b0;
   logic busOwned;
   logic xferAck;
   logic bus_request_out;
   logic dmaCycleDone;
   logic localDmaHalt;
   logic [RETRY_WIDTH-1:0] retry = RETRY_ZERO;
   logic [ADDR_WIDTH-1:0] hostAddr;
   logic [7:0] ackDelay = 8'h02;
   hbr_status_s status;
   int failures = 0;
   int num_checks = 0;

   always #(CLK_PERIOD_NS / 2.0) clk_sys = ~clk_sys;

   hbr_bus_release hbr_bus_release_i (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(1'b1),
      .pins({releaseReq, busOwned, busError, xferAck}), .dmaStart(dmaStart), .error_retry_setting(retry),
      .dmaStartAddr(32'h0000_0100), .errorClear(errorClear), .bus_request_out(bus_request_out),
      .dmaCycleDone(dmaCycleDone), .localDmaHalt(localDmaHalt), .host_dma_address_reg(hostAddr),
      .status(status));

   hbr_host_model hbr_host_model_i (.clk_sys(clk_sys), .rst_n(rst_n), .busReq(bus_request_out),
      .xferActive(status.xferActive), .letGo(releaseReq | status.halted | localDmaHalt),
      .ackDelay(ackDelay), .busOwned(busOwned), .xferAck(xferAck));

   task summarize;
      if (failures == 0 && num_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         failures++;
         $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return bus_request_out;
         1: return status.owner;
         2: return status.xferActive;
         3: return dmaCycleDone;
         default: return localDmaHalt;
      endcase
   endfunction

   // A wait that runs out of cycles is a hang and ends the run.
   task automatic waitFor(input int s, input logic v);
      int n;
      for (n = 0; n < 300 && pick(s) !== v; n++)
         @(negedge clk_sys);
      num_checks++;
      if (n == 300)
      begin
         failures++;
         $display("unexpected at %0t: got %0h expected %0h", $time, pick(s), v);
         summarize();
      end
   endtask

   task idle_noise;
      releaseReq = 1'b1;
      busError = 1'b1;
      repeat (6) @(negedge clk_sys);
      check(status.owner, 32'h0);
      check(status.errorSeen, 32'h0);
      check(localDmaHalt, 32'h0);
      releaseReq = 1'b0;
      busError = 1'b0;
   endtask

   task normal_xfer;
      retry = 4'h1;
      dmaStart = 1'b1;
      waitFor(0, 1'b1);
      waitFor(2, 1'b1);
      repeat (2) @(negedge clk_sys);
      check(bus_request_out, 32'h0);
      waitFor(3, 1'b1);
      check(hostAddr, 32'h0000_0100 + ADDR_STEP);
      dmaStart = 1'b0;
      releaseReq = 1'b1;
      waitFor(1, 1'b0);
      check(localDmaHalt, 32'h0);
      releaseReq = 1'b0;
   endtask

   task retry_xfer;
      retry = 4'h1;
      ackDelay = 8'hFF;
      dmaStart = 1'b1;
      waitFor(2, 1'b1);
      busError = 1'b1;
      @(negedge clk_sys);
      busError = 1'b0;
      ackDelay = 8'h02;
      waitFor(3, 1'b1);
      check(status.halted, 32'h0);
      check(localDmaHalt, 32'h0);
      dmaStart = 1'b0;
      releaseReq = 1'b1;
      waitFor(1, 1'b0);
      releaseReq = 1'b0;
   endtask

   task halt_xfer;
      retry = RETRY_ZERO;
      ackDelay = 8'hFF;
      dmaStart = 1'b1;
      waitFor(2, 1'b1);
      busError = 1'b1;
      @(negedge clk_sys);
      busError = 1'b0;
      waitFor(4, 1'b1);
      waitFor(1, 1'b0);
      check(status.halted, 32'h1);
      repeat (20) @(negedge clk_sys);
      check(bus_request_out, 32'h0);
      check(status.xferActive, 32'h0);
      ackDelay = 8'h02;
      dmaStart = 1'b0;
      errorClear = 1'b1;
      @(negedge clk_sys);
      errorClear = 1'b0;
      @(negedge clk_sys);
      check(localDmaHalt, 32'h0);
   endtask

   initial
   begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      @(negedge clk_sys);
      idle_noise();
      normal_xfer();
      retry_xfer();
      halt_xfer();
      normal_xfer();
      summarize();
   end
endmodule
